// *** include/pipe_pkg.sv ***
// shared constants and carrier types for the fetch/execute pipeline
// assumes a single core clock and synchronous program and data arrays
// Functional notes
// RULE1: non-branch one cycle, branch two cycles
// RULE2: byte addressed program, words at even addresses
// RULE3: pc steps by two, bit zero zero
// RULE4: absolute target word loads pc bits 20:1
// RULE5: relative offset counts single-word instructions
// RULE6: second words carry 1111 plus twelve bits
// RULE7: paired second word feeds its literal onward
// RULE8: lone 1111 word executes as no-op
// RULE9: data space uses a 12-bit address
// RULE10: sixteen banks of 256, two implemented
// RULE11: unimplemented data reads return zeros
// RULE12: direct, indirect, indexed reach every bank
// RULE13: 256-byte access window bypasses bank pointer
// RULE14: clock divided into four phases per cycle
// RULE15: operand read phase two, write phase four
// RULE16: window low half bank 0, high bank 15
// RULE17: access bit one banked, zero window
// RULE18: pipeline starts empty at the reset address
// RULE19: taken skip discards the next fetched word
package pipe_pkg;
    localparam int PC_WORD_W = 20;
    localparam int IR_W      = 16;
    localparam int DADDR_W   = 12;
    localparam int OFS_W     = 8;
    localparam int BANK_W    = 4;
    localparam int NUM_BANKS = 16;
    localparam int REL_W     = 11;
    localparam int LIT_W     = 12;

    localparam logic [PC_WORD_W-1:0] RESET_WORD   = 20'h00000;
    localparam logic [PC_WORD_W-1:0] WORD_STEP    = 20'h00001;
    localparam logic                 PC_LSB       = 1'b0;
    localparam logic [3:0]           SECOND_NIB   = 4'hf;
    localparam logic [BANK_W-1:0]    WIN_LO_BANK  = 4'h0;
    localparam logic [BANK_W-1:0]    WIN_HI_BANK  = 4'hf;
    localparam logic [NUM_BANKS-1:0] IMPL_BANK_MASK = 16'h8001;
    localparam logic [7:0]           ZERO_BYTE    = 8'h00;

    typedef enum logic [3:0] {
        PH_ONE   = 4'b0001,
        PH_TWO   = 4'b0010,
        PH_THREE = 4'b0100,
        PH_FOUR  = 4'b1000
    } phase_t;

    // decode answer from the datapath for the word now executing
    typedef struct packed {
        logic                 branch_abs;
        logic                 branch_rel;
        logic                 skip;
        logic                 two_word;
        logic                 rd;
        logic                 wr;
        logic                 full_mode;
        logic                 access_sel;
        logic [OFS_W-1:0]     offset;
        logic [DADDR_W-1:0]   full_addr;
        logic [PC_WORD_W-1:0] abs_target;
        logic [REL_W-1:0]     rel_offset;
        logic [7:0]           wr_data;
    } exec_ctl_t;

    typedef struct packed {
        logic               rd;
        logic               wr;
        logic [DADDR_W-1:0] addr;
        logic [7:0]         wdata;
    } dm_req_t;
endpackage

// *** verilog/data_addr_map.sv ***
// data memory address formation and implemented-bank decode
// assumes the datapath supplies pointer addresses as full 12-bit values
`timescale 1ns/1ps
module data_addr_map #(
    parameter logic [pipe_pkg::NUM_BANKS-1:0] IMPL_BANKS = pipe_pkg::IMPL_BANK_MASK
) (
    input  wire logic                          full_mode,
    input  wire logic                          access_sel,
    input  wire logic [pipe_pkg::OFS_W-1:0]    offset,
    input  wire logic [pipe_pkg::DADDR_W-1:0]  full_addr,
    input  wire logic [pipe_pkg::BANK_W-1:0]   bank_pointer,
    output logic      [pipe_pkg::DADDR_W-1:0]  addr,
    output logic                               implemented
);
    wire                          window_hi;
    wire [pipe_pkg::BANK_W-1:0]   window_bank;
    wire [pipe_pkg::DADDR_W-1:0]  window_addr;
    wire [pipe_pkg::DADDR_W-1:0]  banked_addr;

    assign window_hi   = offset[pipe_pkg::OFS_W-1];
    assign window_bank = window_hi ? pipe_pkg::WIN_HI_BANK : pipe_pkg::WIN_LO_BANK; // RULE16
    assign window_addr = {window_bank, offset}; // RULE13
    assign banked_addr = {bank_pointer, offset};
    // full and pointer modes reach any of the 4096 locations
    assign addr = full_mode ? full_addr : (access_sel ? banked_addr : window_addr); // RULE17 RULE12 RULE9
    assign implemented = IMPL_BANKS[addr[pipe_pkg::DADDR_W-1 -: pipe_pkg::BANK_W]]; // RULE10
endmodule

// *** verilog/fetch_execute_pipeline.sv ***
// two-stage fetch/execute control with four-phase sequencing and data map
// assumes synchronous program and data arrays answering one clock after address
`timescale 1ns/1ps
module fetch_execute_pipeline #(
    parameter logic [pipe_pkg::PC_WORD_W-1:0] RESET_WORD = pipe_pkg::RESET_WORD,
    parameter logic [pipe_pkg::NUM_BANKS-1:0] IMPL_BANKS = pipe_pkg::IMPL_BANK_MASK
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rstn,
    output logic      [pipe_pkg::PC_WORD_W:0]  pm_addr,
    input  wire logic [pipe_pkg::IR_W-1:0]     pm_rdata,
    output logic      [pipe_pkg::IR_W-1:0]     exec_word,
    output logic                               exec_valid,
    output logic                               exec_second,
    output logic      [pipe_pkg::LIT_W-1:0]    exec_literal,
    input  wire pipe_pkg::exec_ctl_t           exec_ctl,
    input  wire logic [pipe_pkg::BANK_W-1:0]   bank_pointer,
    output pipe_pkg::phase_t                   phase,
    output pipe_pkg::dm_req_t                  dm_req,
    input  wire logic [7:0]                    dm_rdata,
    output logic      [7:0]                    operand
);
    pipe_pkg::phase_t                 next_phase;
    logic [pipe_pkg::PC_WORD_W-1:0]   pc_word;
    logic [pipe_pkg::IR_W-1:0]        ir;
    logic                             ir_valid;
    logic                             second_pending;
    logic                             rd_taken;
    logic                             rd_impl;

    wire                              end_cycle;
    wire                              top_is_second;
    wire                              active;
    wire                              redirect;
    wire                              flush;
    wire [pipe_pkg::PC_WORD_W-1:0]    rel_ext;
    wire [pipe_pkg::PC_WORD_W-1:0]    target_word;
    wire [pipe_pkg::PC_WORD_W-1:0]    next_pc_word;
    wire [pipe_pkg::DADDR_W-1:0]      data_addr;
    wire                              data_impl;

    // four-phase sequencer
    always_comb begin
        case (phase)
            pipe_pkg::PH_ONE:   next_phase = pipe_pkg::PH_TWO;
            pipe_pkg::PH_TWO:   next_phase = pipe_pkg::PH_THREE;
            pipe_pkg::PH_THREE: next_phase = pipe_pkg::PH_FOUR;
            pipe_pkg::PH_FOUR:  next_phase = pipe_pkg::PH_ONE;
            default:            next_phase = pipe_pkg::PH_ONE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase <= pipe_pkg::PH_ONE;
        end else begin
            phase <= next_phase; // RULE14
        end
    end

    assign end_cycle = (phase == pipe_pkg::PH_FOUR);

    // execute-stage decode
    assign top_is_second = (ir[pipe_pkg::IR_W-1 -: 4] == pipe_pkg::SECOND_NIB); // RULE6
    assign exec_word     = ir;
    assign exec_valid    = ir_valid & ~top_is_second; // RULE8
    assign exec_second   = ir_valid & top_is_second & second_pending; // RULE7
    assign exec_literal  = ir[pipe_pkg::LIT_W-1:0]; // RULE7
    assign active        = exec_valid | exec_second;
    assign redirect      = active & (exec_ctl.branch_abs | exec_ctl.branch_rel);
    assign flush         = redirect | (active & exec_ctl.skip); // RULE1 RULE19

    // target formation in word units, bit zero never stored
    assign rel_ext = {{(pipe_pkg::PC_WORD_W - pipe_pkg::REL_W){exec_ctl.rel_offset[pipe_pkg::REL_W-1]}},
                      exec_ctl.rel_offset};
    assign target_word  = exec_ctl.branch_abs ? exec_ctl.abs_target // RULE4
                                              : pc_word + rel_ext; // RULE5
    assign next_pc_word = redirect ? target_word : pc_word + pipe_pkg::WORD_STEP; // RULE3
    assign pm_addr      = {pc_word, pipe_pkg::PC_LSB}; // RULE2 RULE3

    // fetch latch and pipeline state; flushed word runs as a no-op slot
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pc_word        <= RESET_WORD; // RULE18
            ir             <= '0;
            ir_valid       <= 1'b0; // RULE18
            second_pending <= 1'b0;
        end else if (end_cycle) begin
            pc_word        <= next_pc_word;
            ir             <= pm_rdata;
            ir_valid       <= ~flush; // RULE1 RULE19
            second_pending <= exec_valid & exec_ctl.two_word & ~flush; // RULE7
        end
    end

    data_addr_map #(
        .IMPL_BANKS   (IMPL_BANKS)
    ) u_map (
        .full_mode    (exec_ctl.full_mode),
        .access_sel   (exec_ctl.access_sel),
        .offset       (exec_ctl.offset),
        .full_addr    (exec_ctl.full_addr),
        .bank_pointer (bank_pointer),
        .addr         (data_addr),
        .implemented  (data_impl)
    );

    // data strobes; unimplemented banks are never touched
    assign dm_req.rd    = active & exec_ctl.rd & (phase == pipe_pkg::PH_TWO) & data_impl; // RULE15
    assign dm_req.wr    = active & exec_ctl.wr & end_cycle & data_impl; // RULE15
    assign dm_req.addr  = data_addr;
    assign dm_req.wdata = exec_ctl.wr_data;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_taken <= 1'b0;
            rd_impl  <= 1'b0;
        end else begin
            rd_taken <= active & exec_ctl.rd & (phase == pipe_pkg::PH_TWO);
            rd_impl  <= data_impl;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            operand <= pipe_pkg::ZERO_BYTE;
        end else if (rd_taken) begin
            operand <= rd_impl ? dm_rdata : pipe_pkg::ZERO_BYTE; // RULE11
        end
    end

    // checks
    a_branch_flush: assert property ( // RULE1
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && redirect |=> !ir_valid ##4 ir_valid)
        else $error("branch did not flush exactly one word");

    a_pc_step: assert property ( // RULE3
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && !redirect |=> pm_addr == $past(pm_addr) + 21'h000002)
        else $error("pc did not advance by two");

    a_pc_even: assert property ( // RULE2
        @(posedge clk_sys) disable iff (!rstn)
        pm_addr[0] == 1'b0)
        else $error("program address odd");

    a_abs_target: assert property ( // RULE4
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && active && exec_ctl.branch_abs
        |=> pm_addr == {$past(exec_ctl.abs_target), 1'b0})
        else $error("absolute target not loaded into pc bits 20:1");

    a_rel_target: assert property ( // RULE5
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && active && exec_ctl.branch_rel && !exec_ctl.branch_abs
        |=> pm_addr == $past(pm_addr) + {$past(rel_ext), 1'b0})
        else $error("relative target not scaled to words");

    a_second_pairs: assert property ( // RULE7
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && exec_valid && exec_ctl.two_word && !flush
        && pm_rdata[15:12] == pipe_pkg::SECOND_NIB |=> exec_second [*4])
        else $error("paired second word not delivered");

    a_lone_second_nop: assert property ( // RULE8
        @(posedge clk_sys) disable iff (!rstn)
        ir_valid && top_is_second && !second_pending
        |-> !exec_valid && !dm_req.rd && !dm_req.wr && !redirect)
        else $error("lone second word had side effects");

    a_phase_order: assert property ( // RULE14
        @(posedge clk_sys) disable iff (!rstn)
        phase == pipe_pkg::PH_ONE |=> phase == pipe_pkg::PH_TWO
        ##1 phase == pipe_pkg::PH_THREE ##1 phase == pipe_pkg::PH_FOUR)
        else $error("phase order broken");

    a_strobe_phase: assert property ( // RULE15
        @(posedge clk_sys) disable iff (!rstn)
        (dm_req.rd |-> phase == pipe_pkg::PH_TWO) and (dm_req.wr |-> end_cycle))
        else $error("data strobe in wrong phase");

    a_unimpl_zero: assert property ( // RULE11
        @(posedge clk_sys) disable iff (!rstn)
        phase == pipe_pkg::PH_TWO && active && exec_ctl.rd && !data_impl
        |-> !dm_req.rd ##2 operand == pipe_pkg::ZERO_BYTE)
        else $error("unimplemented read not zero");

    a_window_map: assert property ( // RULE16
        @(posedge clk_sys) disable iff (!rstn)
        !exec_ctl.full_mode && !exec_ctl.access_sel
        |-> data_addr == {(exec_ctl.offset[7] ? pipe_pkg::WIN_HI_BANK
                                              : pipe_pkg::WIN_LO_BANK), exec_ctl.offset})
        else $error("access window mapped wrongly");

    a_banked_map: assert property ( // RULE17
        @(posedge clk_sys) disable iff (!rstn)
        !exec_ctl.full_mode && exec_ctl.access_sel
        |-> data_addr == {bank_pointer, exec_ctl.offset})
        else $error("banked address not from bank pointer");

    a_skip_flush: assert property ( // RULE19
        @(posedge clk_sys) disable iff (!rstn)
        end_cycle && active && exec_ctl.skip |=> !exec_valid && !exec_second)
        else $error("skip did not discard next word");

    c_branch: cover property (@(posedge clk_sys) disable iff (!rstn) end_cycle && redirect);
    c_lone_second: cover property (@(posedge clk_sys) disable iff (!rstn)
        ir_valid && top_is_second && !second_pending);
    c_paired_second: cover property (@(posedge clk_sys) disable iff (!rstn) exec_second);
    c_unimpl_read: cover property (@(posedge clk_sys) disable iff (!rstn)
        rd_taken && !rd_impl);
endmodule

// *** bench/mem_model.sv ***
// program and data array model facing the pipeline
// assumes the bench loads both arrays before reset is released
`timescale 1ns/1ps
module mem_model (
    input  wire logic                         clk_sys,
    input  wire logic [pipe_pkg::PC_WORD_W:0] pm_addr,
    output logic      [15:0]                  pm_rdata,
    input  wire pipe_pkg::dm_req_t            dm_req,
    output logic      [7:0]                   dm_rdata
);
    logic [15:0] pmem [32];
    logic [7:0]  dmem [4096];
    // word select ignores the byte bit
    assign pm_rdata = pmem[pm_addr[5:1]];
    initial dm_rdata = 8'h00;
    always @(posedge clk_sys) begin
        if (dm_req.wr === 1'b1) dmem[dm_req.addr] <= dm_req.wdata;
        // read data does not linger after its clock
        if (dm_req.rd === 1'b1) dm_rdata <= dmem[dm_req.addr];
        else dm_rdata <= ~dm_rdata;
    end
endmodule

// *** bench/fetch_execute_pipeline_tb_top.sv ***
// self-checking bench for the fetch/execute pipeline
// assumes mem_model for the arrays; the bench decodes as the datapath
`timescale 1ns/1ps
module fetch_execute_pipeline_tb_top;
    typedef struct packed {
        logic [20:0] pa;
        logic        v;
        logic        s;
        logic [15:0] w;
        logic [7:0]  op;
    } obs_t;
    typedef struct packed {
        logic [3:0]  ph;
        logic [11:0] a;
        logic [7:0]  d;
    } wr_t;
    localparam logic [15:0] PROG [18] = '{16'h1000, 16'h5010, 16'h5105, 16'h5090,
        16'h7345, 16'h6120, 16'h8123, 16'h4000, 16'h2000, 16'hf00c, 16'h2000,
        16'hf00e, 16'h1111, 16'h1222, 16'h3002, 16'h1333, 16'h1555, 16'h5120};
    logic                clk_sys;
    logic                rstn;
    logic [20:0]         pm_addr;
    logic [15:0]         pm_rdata;
    logic [15:0]         exec_word;
    logic                exec_valid;
    logic                exec_second;
    logic [11:0]         exec_literal;
    pipe_pkg::exec_ctl_t exec_ctl;
    logic [3:0]          bank_pointer;
    pipe_pkg::phase_t    phase;
    pipe_pkg::dm_req_t   dm_req;
    logic [7:0]          dm_rdata;
    logic [7:0]          operand;
    logic [7:0]          wval;
    int                  num_errors;
    int                  check_count;
    obs_t                exp_q[$];
    wr_t                 wr_q[$];

    fetch_execute_pipeline fetch_execute_pipeline_i (.clk_sys(clk_sys), .rstn(rstn),
        .pm_addr(pm_addr), .pm_rdata(pm_rdata), .exec_word(exec_word),
        .exec_valid(exec_valid), .exec_second(exec_second), .exec_literal(exec_literal),
        .exec_ctl(exec_ctl), .bank_pointer(bank_pointer), .phase(phase),
        .dm_req(dm_req), .dm_rdata(dm_rdata), .operand(operand));
    mem_model mem_model_i (.clk_sys(clk_sys), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
        .dm_req(dm_req), .dm_rdata(dm_rdata));

    // datapath decode: 2 two-word jump, 3 relative, 4 skip, 5/6 read/write, 7/8 full
    function automatic pipe_pkg::exec_ctl_t decode(input logic [15:0] w, input logic [7:0] d);
        pipe_pkg::exec_ctl_t c;
        c = '0;
        c.two_word = (w[15:12] == 4'h2);
        c.branch_rel = (w[15:12] == 4'h3);
        c.skip = (w[15:12] == 4'h4);
        c.rd = (w[15:12] == 4'h5) || (w[15:12] == 4'h7);
        c.wr = (w[15:12] == 4'h6) || (w[15:12] == 4'h8);
        c.full_mode = (w[15:12] == 4'h7) || (w[15:12] == 4'h8);
        c.branch_abs = (w[15:12] == 4'hf);
        c.access_sel = w[8];
        c.offset = w[7:0];
        c.full_addr = w[11:0];
        c.abs_target = {8'h00, w[11:0]};
        c.rel_offset = w[10:0];
        c.wr_data = d;
        return c;
    endfunction
    always_comb exec_ctl = decode(exec_word, wval);

    task automatic note(input logic [20:0] pa, input logic v, input logic s,
                        input logic [15:0] w, input logic [7:0] op);
        exp_q.push_back(obs_t'({pa, v, s, w, op}));
    endtask
    task automatic check_obs(input obs_t got, input obs_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_wr(input wr_t got, input wr_t exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // one note per instruction cycle, taken at its phase-four edge
    always @(posedge clk_sys) begin
        if (rstn === 1'b1 && phase === pipe_pkg::PH_FOUR && exp_q.size() > 0) begin
            check_obs({pm_addr, exec_valid, exec_second, exec_word, operand},
                      exp_q.pop_front());
        end
        if (rstn === 1'b1 && dm_req.wr === 1'b1) begin
            check_wr({phase, dm_req.addr, dm_req.wdata},
                     wr_q.size() > 0 ? wr_q.pop_front() : '1);
        end
    end

    initial begin
        rstn = 1'b0;
        bank_pointer = 4'h0;
        num_errors = 0;
        check_count = 0;
        wval = 8'($urandom(32'hd2c1bab4));
        for (int i = 0; i < 4096; i++) mem_model_i.dmem[i] = 8'($urandom);
        for (int i = 0; i < 32; i++) mem_model_i.pmem[i] = (i < 18) ? PROG[i] : 16'h1000;
        note(21'h000, 1'b0, 1'b0, 16'h0000, 8'h00);
        note(21'h002, 1'b1, 1'b0, 16'h1000, 8'h00);
        note(21'h004, 1'b1, 1'b0, 16'h5010, mem_model_i.dmem[12'h010]);
        note(21'h006, 1'b1, 1'b0, 16'h5105, mem_model_i.dmem[12'hf05]);
        note(21'h008, 1'b1, 1'b0, 16'h5090, mem_model_i.dmem[12'hf90]);
        note(21'h00a, 1'b1, 1'b0, 16'h7345, 8'h00);
        note(21'h00c, 1'b1, 1'b0, 16'h6120, 8'h00);
        note(21'h00e, 1'b1, 1'b0, 16'h8123, 8'h00);
        note(21'h010, 1'b1, 1'b0, 16'h4000, 8'h00);
        note(21'h012, 1'b0, 1'b0, 16'h2000, 8'h00);
        note(21'h014, 1'b0, 1'b0, 16'hf00c, 8'h00);
        note(21'h016, 1'b1, 1'b0, 16'h2000, 8'h00);
        note(21'h018, 1'b0, 1'b1, 16'hf00e, 8'h00);
        note(21'h01c, 1'b0, 1'b0, 16'h1111, 8'h00);
        note(21'h01e, 1'b1, 1'b0, 16'h3002, 8'h00);
        note(21'h022, 1'b0, 1'b0, 16'h1333, 8'h00);
        note(21'h024, 1'b1, 1'b0, 16'h5120, wval);
        wr_q.push_back({pipe_pkg::PH_FOUR, 12'hf20, wval});
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        bank_pointer <= 4'hf;
        for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(posedge clk_sys);
        if (exp_q.size() > 0 || wr_q.size() > 0) num_errors++;
        repeat (4) @(posedge clk_sys);
        finish_test();
    end
endmodule
